//--- logic/ddsl_pkg.sv
package ddsl_pkg;
    // serial frame layout
    localparam int FRAME_BITS = 16;
    localparam int CODE_BITS = 12;
    localparam int ADDR_BIT_POS = 15;
    localparam int SHUTDOWN_BIT_POS = 14 - 1;
    localparam int ZERO_BIT_POS = 12;
    localparam int CODE_MSB = 11;
    localparam int BITCNT_W = 5;
    localparam logic [BITCNT_W-1:0] BITCNT_ZERO = 5'h00;
    localparam logic [BITCNT_W-1:0] BITCNT_ONE = 5'h01;
    localparam logic [BITCNT_W-1:0] BITCNT_LAST = 5'h0f;
    localparam logic [BITCNT_W-1:0] BITCNT_FRAME = 5'h10;
    // twos complement zero gives the bipolar-zero level
    localparam logic [CODE_BITS-1:0] ZERO_CODE = 12'h000;
    localparam logic [FRAME_BITS-1:0] SHIFT_RESET = 16'h0000;

    // host register map (byte addresses, one word each)
    localparam int WB_ADR_W = 4;
    localparam logic [WB_ADR_W-1:0] REG_FRAME_ADDR = 4'h0;
    localparam logic [WB_ADR_W-1:0] REG_STATUS_ADDR = 4'h4;
    localparam logic [WB_ADR_W-1:0] REG_RELEASE_ADDR = 4'h8;
    localparam int STATUS_BUSY_POS = 0;
    localparam int STATUS_DROP_POS = 1;
    localparam int STATUS_SHDN_POS = 2;
    localparam int STATUS_SHDN_ADDR_POS = 3;

    // link timing
    localparam int SYS_PERIOD_NS = 50;
    localparam int T_CS_HIGH_NS = 30;
    localparam int CS_HIGH_RAW = (T_CS_HIGH_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int CS_HIGH_CYCLES = (CS_HIGH_RAW < 1) ? 1 : CS_HIGH_RAW;
    localparam int GAP_W = 4;

    typedef enum logic [1:0] {
        DEV_WAIT_HIGH = 2'b00,
        DEV_ARMED = 2'b01,
        DEV_SHIFT = 2'b10,
        DEV_DONE = 2'b11
    } ddsl_dev_state_t;

    typedef enum logic [1:0] {
        HOST_IDLE = 2'b00,
        HOST_SHIFT = 2'b01,
        HOST_GAP = 2'b10
    } ddsl_host_state_t;
endpackage

//--- logic/ddsl_link_if.sv
`timescale 1ns/100ps
interface ddsl_link_if;
    logic link_clk;
    logic frame_sel_n;
    logic serial_data_in;

    modport host (
        output link_clk,
        output frame_sel_n,
        output serial_data_in
    );

    modport device (
        input link_clk,
        input frame_sel_n,
        input serial_data_in
    );
endinterface

//--- logic/ddsl_device.sv
`timescale 1ns/100ps
module ddsl_device
    import ddsl_pkg::*;
(
    ddsl_link_if.device link,
    input wire logic reset_i,
    output logic [CODE_BITS-1:0] channel_a_output_o,
    output logic [CODE_BITS-1:0] channel_b_output_o,
    output logic channel_a_drive_o,
    output logic channel_b_drive_o,
    output logic bipolar_zero_ref_drive_o,
    output logic shutdown_o,
    output logic frame_load_o,
    output logic zero_bit_error_o
);

    ddsl_dev_state_t state_reg;
    ddsl_dev_state_t state_next;
    logic [BITCNT_W-1:0] bit_cnt_reg;
    logic [BITCNT_W-1:0] bit_cnt_next;
    logic [FRAME_BITS-1:0] shift_reg;
    logic [FRAME_BITS-1:0] shift_next;
    logic [CODE_BITS-1:0] chan_a_reg;
    logic [CODE_BITS-1:0] chan_a_next;
    logic [CODE_BITS-1:0] chan_b_reg;
    logic [CODE_BITS-1:0] chan_b_next;
    logic shutdown_reg;
    logic shutdown_next;
    logic shutdown_addr_reg;
    logic shutdown_addr_next;
    logic drive_reg;
    logic drive_next;
    logic load_reg;
    logic load_next;
    logic zero_err_reg;
    logic zero_err_next;
    logic [FRAME_BITS-1:0] word;

    // msb first: older bits move up, the newest bit enters at the bottom
    function automatic logic [FRAME_BITS-1:0] shift_in(
        input logic [FRAME_BITS-1:0] cur,
        input logic bit_in
    );
        shift_in = {cur[FRAME_BITS-2:0], bit_in};
    endfunction

    always_comb begin
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg;
        shift_next = shift_reg;
        chan_a_next = chan_a_reg;
        chan_b_next = chan_b_reg;
        shutdown_next = shutdown_reg;
        shutdown_addr_next = shutdown_addr_reg;
        zero_err_next = zero_err_reg;
        load_next = 1'b0;
        word = shift_in(shift_reg, link.serial_data_in);
        if (link.frame_sel_n) begin
            // select high: arm for the next falling edge, drop any partial frame
            state_next = DEV_ARMED;
            bit_cnt_next = BITCNT_ZERO;
        end else begin
            case (state_reg)
                DEV_WAIT_HIGH: begin
                    // no select falling edge seen since reset yet
                    state_next = DEV_WAIT_HIGH;
                end
                DEV_ARMED: begin
                    shift_next = word;
                    bit_cnt_next = BITCNT_ONE;
                    state_next = DEV_SHIFT;
                end
                DEV_SHIFT: begin
                    shift_next = word;
                    if (bit_cnt_reg == BITCNT_LAST) begin
                        // 16th edge: commit at once, select need not rise
                        state_next = DEV_DONE;
                        bit_cnt_next = BITCNT_ZERO;
                        load_next = 1'b1;
                        zero_err_next = word[ZERO_BIT_POS];
                        // channel code is stored even while shut down
                        if (word[ADDR_BIT_POS]) begin
                            chan_b_next = word[CODE_MSB:0];
                        end else begin
                            chan_a_next = word[CODE_MSB:0];
                        end
                        if (word[SHUTDOWN_BIT_POS]) begin
                            shutdown_next = 1'b1;
                            shutdown_addr_next = word[ADDR_BIT_POS];
                        end else if (shutdown_reg &&
                                     word[ADDR_BIT_POS] == shutdown_addr_reg) begin
                            shutdown_next = 1'b0;
                        end
                    end else begin
                        bit_cnt_next = bit_cnt_reg + BITCNT_ONE;
                    end
                end
                DEV_DONE: begin
                    // extra edges are ignored until select goes high again
                    state_next = DEV_DONE;
                end
                default: begin
                    state_next = DEV_WAIT_HIGH;
                end
            endcase
        end
        drive_next = ~shutdown_next;
    end

    // everything here runs on the link clock; there is no other clock
    always_ff @(posedge link.link_clk) begin
        if (reset_i) begin
            state_reg <= DEV_WAIT_HIGH;
            bit_cnt_reg <= BITCNT_ZERO;
            shift_reg <= SHIFT_RESET;
            chan_a_reg <= ZERO_CODE;
            chan_b_reg <= ZERO_CODE;
            shutdown_reg <= 1'b0;
            shutdown_addr_reg <= 1'b0;
            drive_reg <= 1'b1;
            load_reg <= 1'b0;
            zero_err_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            chan_a_reg <= chan_a_next;
            chan_b_reg <= chan_b_next;
            shutdown_reg <= shutdown_next;
            shutdown_addr_reg <= shutdown_addr_next;
            drive_reg <= drive_next;
            load_reg <= load_next;
            zero_err_reg <= zero_err_next;
        end
    end

    assign channel_a_output_o = chan_a_reg;
    assign channel_b_output_o = chan_b_reg;
    assign channel_a_drive_o = drive_reg;
    assign channel_b_drive_o = drive_reg;
    assign bipolar_zero_ref_drive_o = drive_reg;
    assign shutdown_o = shutdown_reg;
    assign frame_load_o = load_reg;
    assign zero_bit_error_o = zero_err_reg;

endmodule

//--- logic/ddsl_host.sv
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
module ddsl_host
    import ddsl_pkg::*;
#(
    parameter int HALF_DIV = 1
)
(
    ddsl_link_if.host link,
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [WB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    localparam logic [7:0] DIV_LAST = 8'(HALF_DIV - 1);
    localparam logic [GAP_W-1:0] GAP_MIN = GAP_W'(CS_HIGH_CYCLES);

    logic [7:0] div_cnt_reg;
    logic [7:0] div_cnt_next;
    logic clk_reg;
    logic clk_next;
    logic tick_fall;
    logic tick_rise;

    ddsl_host_state_t state_reg;
    ddsl_host_state_t state_next;
    logic [FRAME_BITS-1:0] word_reg;
    logic [FRAME_BITS-1:0] word_next;
    logic [FRAME_BITS-1:0] tx_reg;
    logic [FRAME_BITS-1:0] tx_next;
    logic [BITCNT_W-1:0] cnt_reg;
    logic [BITCNT_W-1:0] cnt_next;
    logic [GAP_W-1:0] gap_reg;
    logic [GAP_W-1:0] gap_next;
    logic pending_reg;
    logic pending_next;
    logic cs_n_reg;
    logic cs_n_next;
    logic sdo_reg;
    logic sdo_next;
    logic drop_reg;
    logic drop_next;
    logic shdn_reg;
    logic shdn_next;
    logic shdn_addr_reg;
    logic shdn_addr_next;
    logic ack_reg;
    logic ack_next;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    logic access;
    logic busy;

    // the link clock runs free so the device sees select high at a rising edge
    always_comb begin
        tick_fall = (div_cnt_reg == DIV_LAST) && clk_reg;
        tick_rise = (div_cnt_reg == DIV_LAST) && !clk_reg;
        div_cnt_next = div_cnt_reg + 8'h01;
        clk_next = clk_reg;
        if (div_cnt_reg == DIV_LAST) begin
            div_cnt_next = 8'h00;
            clk_next = ~clk_reg;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            div_cnt_reg <= 8'h00;
            clk_reg <= 1'b0;
        end else begin
            div_cnt_reg <= div_cnt_next;
            clk_reg <= clk_next;
        end
    end

    always_comb begin
        state_next = state_reg;
        word_next = word_reg;
        tx_next = tx_reg;
        cnt_next = cnt_reg;
        gap_next = gap_reg;
        pending_next = pending_reg;
        cs_n_next = cs_n_reg;
        sdo_next = sdo_reg;
        drop_next = drop_reg;
        shdn_next = shdn_reg;
        shdn_addr_next = shdn_addr_reg;
        access = wb_cyc_i && wb_stb_i && !ack_reg;
        busy = pending_reg || (state_reg != HOST_IDLE);
        ack_next = access;
        dat_next = 32'h0000_0000;

        // only the low two byte lanes carry a frame; a write needs both
        if (access && wb_we_i && wb_sel_i[1:0] == 2'b11) begin
            if (wb_adr_i == REG_FRAME_ADDR || wb_adr_i == REG_RELEASE_ADDR) begin
                if (busy) begin
                    drop_next = 1'b1;
                end else begin
                    pending_next = 1'b1;
                    drop_next = 1'b0;
                    word_next = wb_dat_i[FRAME_BITS-1:0];
                    word_next[ZERO_BIT_POS] = 1'b0;
                    if (wb_adr_i == REG_RELEASE_ADDR) begin
                        // release reuses the address of the frame that shut down
                        word_next[ADDR_BIT_POS] = shdn_addr_reg;
                        word_next[SHUTDOWN_BIT_POS] = 1'b0;
                    end
                end
            end
        end else if (access && !wb_we_i) begin
            if (wb_adr_i == REG_FRAME_ADDR) begin
                dat_next[FRAME_BITS-1:0] = word_reg;
            end else if (wb_adr_i == REG_STATUS_ADDR) begin
                dat_next[STATUS_BUSY_POS] = busy;
                dat_next[STATUS_DROP_POS] = drop_reg;
                dat_next[STATUS_SHDN_POS] = shdn_reg;
                dat_next[STATUS_SHDN_ADDR_POS] = shdn_addr_reg;
            end
        end

        case (state_reg)
            HOST_IDLE: begin
                if (pending_reg && tick_fall) begin
                    // select falls with the top bit already on the data line
                    cs_n_next = 1'b0;
                    sdo_next = word_reg[FRAME_BITS-1];
                    tx_next = {word_reg[FRAME_BITS-2:0], 1'b0};
                    cnt_next = BITCNT_ONE;
                    pending_next = 1'b0;
                    state_next = HOST_SHIFT;
                    if (word_reg[SHUTDOWN_BIT_POS]) begin
                        shdn_next = 1'b1;
                        shdn_addr_next = word_reg[ADDR_BIT_POS];
                    end else if (word_reg[ADDR_BIT_POS] == shdn_addr_reg) begin
                        shdn_next = 1'b0;
                    end
                end
            end
            HOST_SHIFT: begin
                if (tick_fall) begin
                    if (cnt_reg == BITCNT_FRAME) begin
                        // 16 rising edges done: raise select before any new frame
                        cs_n_next = 1'b1;
                        gap_next = {GAP_W{1'b0}};
                        state_next = HOST_GAP;
                    end else begin
                        sdo_next = tx_reg[FRAME_BITS-1];
                        tx_next = {tx_reg[FRAME_BITS-2:0], 1'b0};
                        cnt_next = cnt_reg + BITCNT_ONE;
                    end
                end
            end
            HOST_GAP: begin
                if (gap_reg != GAP_MIN) begin
                    gap_next = gap_reg + {{(GAP_W-1){1'b0}}, 1'b1};
                end
                // a rising edge with select high re-arms the device
                if (tick_rise && gap_reg == GAP_MIN) begin
                    state_next = HOST_IDLE;
                end
            end
            default: begin
                state_next = HOST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_reg <= HOST_IDLE;
            word_reg <= SHIFT_RESET;
            tx_reg <= SHIFT_RESET;
            cnt_reg <= BITCNT_ZERO;
            gap_reg <= {GAP_W{1'b0}};
            pending_reg <= 1'b0;
            cs_n_reg <= 1'b1;
            sdo_reg <= 1'b0;
            drop_reg <= 1'b0;
            shdn_reg <= 1'b0;
            shdn_addr_reg <= 1'b0;
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            word_reg <= word_next;
            tx_reg <= tx_next;
            cnt_reg <= cnt_next;
            gap_reg <= gap_next;
            pending_reg <= pending_next;
            cs_n_reg <= cs_n_next;
            sdo_reg <= sdo_next;
            drop_reg <= drop_next;
            shdn_reg <= shdn_next;
            shdn_addr_reg <= shdn_addr_next;
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    assign link.link_clk = clk_reg;
    assign link.frame_sel_n = cs_n_reg;
    assign link.serial_data_in = sdo_reg;
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

endmodule

//--- tb/ddsl_props.sv
`timescale 1ns/100ps
module ddsl_props
    import ddsl_pkg::*;
(
    input wire logic link_clk,
    input wire logic frame_sel_n,
    input wire logic serial_data_in,
    input wire logic reset_i,
    input wire logic [CODE_BITS-1:0] channel_a_output_o,
    input wire logic [CODE_BITS-1:0] channel_b_output_o,
    input wire logic channel_a_drive_o,
    input wire logic channel_b_drive_o,
    input wire logic bipolar_zero_ref_drive_o,
    input wire logic shutdown_o,
    input wire logic frame_load_o,
    input wire logic zero_bit_error_o
);
    logic [4:0] cnt_reg;
    logic [15:0] sh_reg;
    logic hit_reg;
    logic sda_reg;
    logic rs_reg;
    // reference shifter; hit_reg marks the cycle after the 16th edge
    always_ff @(posedge link_clk) begin
        if (reset_i || frame_sel_n) begin
            cnt_reg <= 5'h00;
        end else if (cnt_reg < 5'h10) begin
            cnt_reg <= cnt_reg + 5'h01;
            sh_reg <= {sh_reg[14:0], serial_data_in};
        end
        hit_reg <= !reset_i && !frame_sel_n && cnt_reg == 5'h0f;
        rs_reg <= reset_i;
        if (reset_i) begin
            sda_reg <= 1'b0;
        end else if (hit_reg && sh_reg[13]) begin
            sda_reg <= sh_reg[15];
        end
    end
    default clocking dc @(posedge link_clk); endclocking
    default disable iff (reset_i);
    a_load_timing: assert property (frame_load_o == hit_reg)
        else $error("load pulse misplaced");
    a_route_a: assert property (hit_reg && !sh_reg[15] |->
        channel_a_output_o == sh_reg[11:0] && $stable(channel_b_output_o))
        else $error("channel a load wrong");
    a_route_b: assert property (hit_reg && sh_reg[15] |->
        channel_b_output_o == sh_reg[11:0] && $stable(channel_a_output_o))
        else $error("channel b load wrong");
    a_codes_hold: assert property (!hit_reg && !rs_reg |->
        $stable(channel_a_output_o) && $stable(channel_b_output_o))
        else $error("code changed without frame");
    a_drive_off: assert property (channel_a_drive_o == !shutdown_o &&
        channel_b_drive_o == !shutdown_o && bipolar_zero_ref_drive_o == !shutdown_o)
        else $error("drive enables disagree");
    a_shdn_enter: assert property (hit_reg && sh_reg[13] |-> shutdown_o)
        else $error("shutdown not entered");
    a_shdn_leave: assert property (hit_reg && !sh_reg[13] |->
        shutdown_o == ($past(shutdown_o) && sh_reg[15] != sda_reg))
        else $error("shutdown release wrong");
    a_shdn_hold: assert property (!hit_reg && !rs_reg |-> $stable(shutdown_o))
        else $error("shutdown changed without frame");
    a_zero_bit: assert property (hit_reg |-> zero_bit_error_o == sh_reg[12])
        else $error("zero bit flag wrong");
    a_sel_release: assert property (hit_reg |-> frame_sel_n)
        else $error("select not raised after frame");
endmodule

//--- tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import ddsl_pkg::*;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic dev_rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] dout;
    logic [15:0] mon;
    logic [11:0] ca, cb, xa, xb;
    logic ack, da, db, dz, sd, ld, zb, xld;
    int fails = 0;
    int comparisons = 0;
    int n_ld = 0;
    int n_xld = 0;
    ddsl_link_if lk ();
    ddsl_link_if lk2 ();
    ddsl_host ddsl_host_i (.link(lk.host), .sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack));
    ddsl_device ddsl_device_i (.link(lk.device), .reset_i(dev_rst),
        .channel_a_output_o(ca), .channel_b_output_o(cb), .channel_a_drive_o(da),
        .channel_b_drive_o(db), .bipolar_zero_ref_drive_o(dz), .shutdown_o(sd),
        .frame_load_o(ld), .zero_bit_error_o(zb));
    // second device, driven by hand to break the framing on purpose
    ddsl_device ddsl_device_x_i (.link(lk2.device), .reset_i(dev_rst),
        .channel_a_output_o(xa), .channel_b_output_o(xb), .channel_a_drive_o(),
        .channel_b_drive_o(), .bipolar_zero_ref_drive_o(), .shutdown_o(),
        .frame_load_o(xld), .zero_bit_error_o());
    ddsl_props ddsl_props_i (.link_clk(lk.link_clk), .frame_sel_n(lk.frame_sel_n),
        .serial_data_in(lk.serial_data_in), .reset_i(dev_rst), .channel_a_output_o(ca),
        .channel_b_output_o(cb), .channel_a_drive_o(da), .channel_b_drive_o(db),
        .bipolar_zero_ref_drive_o(dz), .shutdown_o(sd), .frame_load_o(ld),
        .zero_bit_error_o(zb));
    initial begin
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge ld) n_ld++;
    always @(posedge xld) n_xld++;
    always @(posedge lk.link_clk) begin
        if (!lk.frame_sel_n) begin
            mon <= {mon[14:0], lk.serial_data_in};
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        // ack is judged only at rising edges; the request stands until then
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            fails++;
        end
        rdat = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wait_load(input int n0);
        repeat (400) if (n_ld == n0) @(posedge sys_clk_i);
        if (n_ld == n0) begin
            fails++;
        end
        rdat = 32'h1;
        // a write while busy is dropped, so wait for idle first
        repeat (20) if (rdat[0] !== 1'b0) wb(1'b0, REG_STATUS_ADDR, 32'h0);
        if (rdat[0] !== 1'b0) begin
            fails++;
        end
    endtask
    task automatic frame(input logic [3:0] a, input logic [15:0] w);
        int n0;
        n0 = n_ld;
        wb(1'b1, a, {16'h0, w});
        wait_load(n0);
    endtask
    task automatic tick2;
        #16 lk2.link_clk = 1'b1;
        #16 lk2.link_clk = 1'b0;
    endtask
    task automatic bang(input logic [19:0] w, input int n);
        lk2.frame_sel_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            lk2.serial_data_in = w[19-i];
            tick2();
        end
        lk2.frame_sel_n = 1'b1;
        lk2.serial_data_in = ~lk2.serial_data_in;
        tick2();
    endtask
    task automatic t_route;
        logic [15:0] w [4] = '{16'h0a5c, 16'h8123, 16'hc7ff, 16'h1456};
        foreach (w[i]) begin
            frame(REG_FRAME_ADDR, w[i]);
            chk(w[i][15] ? cb : ca, w[i][11:0]);
            chk(mon, w[i] & 16'hefff);
            chk({sd, zb, lk.frame_sel_n}, 3'b001);
            wb(1'b0, REG_FRAME_ADDR, 32'h0);
            chk(rdat, {16'h0, w[i] & 16'hefff});
        end
    endtask
    task automatic t_shdn;
        frame(REG_FRAME_ADDR, 16'h2001);
        chk({sd, da, db, dz, ca}, {4'b1000, 12'h001});
        frame(REG_FRAME_ADDR, 16'h8042);
        chk({sd, cb}, {1'b1, 12'h042});
        wb(1'b0, REG_STATUS_ADDR, 32'h0);
        chk(rdat, 32'h4);
        frame(REG_RELEASE_ADDR, 16'h0234);
        chk({sd, da, db, dz, ca}, {4'b0111, 12'h234});
        chk(mon, 16'h0234);
    endtask
    task automatic t_drop;
        int n0;
        n0 = n_ld;
        wb(1'b1, REG_FRAME_ADDR, 32'h0111);
        wb(1'b1, REG_FRAME_ADDR, 32'h0222);
        wb(1'b0, REG_STATUS_ADDR, 32'h0);
        chk(rdat[1:0], 2'b11);
        wait_load(n0);
        chk(n_ld - n0, 32'h1);
        chk(ca, 12'h111);
        wb(1'b0, 4'hc, 32'h0);
        chk(rdat, 32'h0);
    endtask
    task automatic t_raw;
        // one edge with select high arms the device, so the partial frame is really shifted
        tick2();
        bang({16'h8abc, 4'h0}, 8);
        chk({n_xld[3:0], xb}, 16'h0000);
        bang({16'h8abc, 4'hf}, 20);
        chk({n_xld[3:0], xb, xa}, {16'h1abc, 12'h000});
    endtask
    initial begin
        lk2.link_clk = 1'b0;
        lk2.frame_sel_n = 1'b1;
        lk2.serial_data_in = 1'b0;
        repeat (5) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        // device reset needs link clock edges on both links
        repeat (4) tick2();
        repeat (8) @(posedge sys_clk_i);
        // release away from a rising link edge so the device sees it cleanly
        @(negedge lk.link_clk);
        dev_rst <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        chk({ca, cb, da, db, dz, sd, ld, zb}, {24'h0, 6'b111000});
        t_route();
        t_shdn();
        t_drop();
        t_raw();
        print_verdict();
    end
    initial begin
        #400000;
        fails++;
        print_verdict();
    end
endmodule
